// file: test/catc_pin_src.sv
`timescale 1ns/1ps
module catc_pin_src #(parameter int HOLD = 8) (
	input  wire logic       clk_i, // clock
	input  wire logic       go_i,  // rise asks one pulse
	output logic      [2:0] line_o // trigger pins
);
	int n = 0;
	// held well past the pin synchroniser so the edge is never lost
	always @(posedge clk_i)
		n <= $rose(go_i) ? HOLD : (n > 0 ? n - 1 : 0);
	assign line_o = {2'b00, n > 0};
endmodule : catc_pin_src

// file: test/catc_sva.sv
`timescale 1ns/1ps
module catc_sva #(parameter logic [15:0] XFER_CYCLES = 16'h0010) (
	input wire logic [0:0]        clk_i,    // clk
	input wire logic [0:0]        rst_i,    // rst
	input wire logic [0:0]        wb_cyc_i, // cyc
	input wire logic [0:0]        wb_stb_i, // stb
	input wire logic [0:0]        wb_we_i,  // we
	input wire logic [7:0]        wb_adr_i, // adr
	input wire logic [3:0]        wb_sel_i, // sel
	input wire logic [31:0]       wb_dat_i, // wdata
	input wire logic [31:0]       wb_dat_o, // rdata
	input wire logic [0:0]        wb_ack_o, // ack
	input wire catc_pkg::catc_status_t status_o  // status
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic cmd;
	assign cmd = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & (wb_adr_i[7:2] == 6'h01) & wb_sel_i[0];
	a_ack_reply: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
	a_dat_quiet: assert property (!wb_ack_o || wb_we_i |-> wb_dat_o == 32'h0) else $error("stray data");
	a_reset_idle: assert property ($fell(rst_i) |-> status_o == 7'h00 && !wb_ack_o) else $error("reset");
	// transfer bits may still drain after capture ends, so they are masked out
	a_abort_idle: assert property (cmd && wb_dat_i[3] && !wb_dat_i[1] |=> (status_o & 7'h5B) == 7'h00) else $error("abort");
	a_stop_wait: assert property (cmd && wb_dat_i[2] && !wb_dat_i[1]
		&& (status_o[0] || status_o[3]) |=> (status_o & 7'h5B) == 7'h00) else $error("stop");
	a_expo_frame: assert property (status_o[6] |-> status_o[4] && status_o[1]) else $error("expo");
	a_frame_acq: assert property ($rose(status_o[4]) |-> status_o[1]) else $error("frame");
	c_expose: cover property (status_o[6]);
	c_abort: cover property (cmd && wb_dat_i[3] && status_o[1]);
	c_xfer: cover property ($fell(status_o[5]));
endmodule : catc_sva

// file: test/test_catc_top.sv
`timescale 1ns/1ps
module test_catc_top;
	logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, go = 1'b0, wb_ack_o;
	logic [1:0] timer_start_i = 2'h0, timer_end_i = 2'h0, counter_start_i = 2'h0, counter_end_i = 2'h0, user_bit_i = 2'h0;
	logic [2:0] trig_line_i;
	logic [3:0] wb_sel_i = 4'hF;
	logic [7:0] wb_adr_i = 8'h00, ia[5] = '{8'h08, 8'h18, 8'h34, 8'h10, 8'h24};
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r, rng = 32'h0000396F, id[5] = '{32'h0, 32'h8, 32'h28, 32'h40, 32'h3};
	catc_pkg::catc_status_t status_o;
	int mismatches = 0, tests_run = 0, mdl[7] = '{0, 1, 0, 1, 0, 0, 0};
	always #2.5 clk_i = ~clk_i;
	catc_top #(.XFER_CYCLES(16'h0004)) dut_u (.*);
	catc_pin_src #(.HOLD(8)) src_u (.clk_i(clk_i), .go_i(go), .line_o(trig_line_i));
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction : xs
	task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		mismatches += int'(s !== e);
		if (s !== e)
			$display("ERROR %s expected %h seen %h", nm, e, s);
	endtask : check
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
		@(posedge clk_i);
		for (int n = 0; wb_ack_o !== 1'b1 && n < 20; n++)
			@(posedge clk_i);
		check("ack", 32'(wb_ack_o), 32'h1);
		r = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		@(posedge clk_i);
	endtask : xfer
	task automatic sp(input int p, input int e);
		xfer(1'b1, 8'h1C, 32'(p));
		xfer(1'b0, 8'h20, 32'h0);
		check("status", r, 32'(e));
	endtask : sp
	task automatic await(input int b, input logic v);
		for (int n = 0; status_o[b] !== v && n < 4000; n++)
			@(posedge clk_i);
		check("state", 32'(status_o[b]), 32'(v));
	endtask : await
	task automatic run(input logic [31:0] cfg, input logic [31:0] pol, input int b);
		await(1, 1'b0);
		xfer(1'b1, 8'h28, cfg);
		xfer(1'b1, 8'h00, pol);
		xfer(1'b1, 8'h04, 32'h2);
		await(b, 1'b1);
	endtask : run
	task automatic finish_test(input int late);
		mismatches += late;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test
	initial #100000 finish_test(1);
	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		xfer(1'b0, 8'h40, 32'h0);
		check("unmapped", r, 32'h0);
		foreach (ia[i])
			xfer(1'b1, ia[i], id[i]);
		xfer(1'b0, 8'h08, 32'h0);
		check("frames", r, 32'h1);
		repeat (3)
		begin
			rng = xs(rng);
			{timer_start_i, timer_end_i, counter_start_i, counter_end_i, user_bit_i} <= rng[9:0];
			xfer(1'b1, 8'h0C, rng);
			xfer(1'b0, 8'h0C, 32'h0);
			check("frame_hz", r, (rng > 32'h0BEBC200) ? 32'h0BEBC200 : rng);
		end
		run(32'h1, 32'h0, 3);
		for (int p = 0; p < 7; p++)
			sp(p, mdl[p]);
		xfer(1'b1, 8'h04, 32'h10);
		await(6, 1'b1);
		sp(4, 1);
		run(32'h11, 32'h0, 3);
		go <= 1'b1;
		await(6, 1'b1);
		run(32'h0, 32'h2, 6);
		xfer(1'b1, 8'h04, 32'h4);
		run(32'h0, 32'h2, 4);
		xfer(1'b1, 8'h04, 32'h8);
		check("abort", 32'(status_o), 32'h0);
		finish_test(0);
	end
endmodule : test_catc_top
bind catc_top catc_sva #(.XFER_CYCLES(XFER_CYCLES)) sva_u (.*);

// file: verilog/catc_pkg.sv
package catc_pkg;
	localparam logic [31:0] CLK_HZ        = 32'h0BEBC200;
	localparam logic [23:0] CLK_PERIOD_NS = 24'h000005;
	localparam int          NUM_TRIG      = 10;
	localparam int          NUM_LINES     = 3;
	localparam int          NUM_STAT      = 7;

	localparam logic [7:0] ADR_CTRL        = 8'h00;
	localparam logic [7:0] ADR_CMD         = 8'h04;
	localparam logic [7:0] ADR_FRAME_TOTAL = 8'h08;
	localparam logic [7:0] ADR_FRAME_HZ    = 8'h0C;
	localparam logic [7:0] ADR_FRAME_UNITS = 8'h10;
	localparam logic [7:0] ADR_LINE_HZ     = 8'h14;
	localparam logic [7:0] ADR_LINE_UNITS  = 8'h18;
	localparam logic [7:0] ADR_STAT_PICK   = 8'h1C;
	localparam logic [7:0] ADR_STAT_VALUE  = 8'h20;
	localparam logic [7:0] ADR_TRIG_PICK   = 8'h24;
	localparam logic [7:0] ADR_TRIG_CFG    = 8'h28;
	localparam logic [7:0] ADR_TRIG_WAIT   = 8'h2C;
	localparam logic [7:0] ADR_TRIG_RATIO  = 8'h30;
	localparam logic [7:0] ADR_EXPO_CYC    = 8'h34;
	localparam logic [7:0] ADR_LINES       = 8'h38;
	localparam logic [7:0] ADR_TRIG_WAITNS = 8'h3C;

	localparam int CMD_ARM    = 0;
	localparam int CMD_BEGIN  = 1;
	localparam int CMD_FINISH = 2;
	localparam int CMD_KILL   = 3;
	localparam int CMD_FIRE   = 4;

	localparam int CFG_ON         = 0;
	localparam int CFG_ORIGIN_LSB = 4;
	localparam int CFG_QUAL_LSB   = 8;
	localparam int CFG_WIN_LSB    = 12;
	localparam int RATIO_UP_LSB   = 8;

	localparam int TK_ACQ_START  = 0;
	localparam int TK_ACQ_END    = 1;
	localparam int TK_ACQ_ACTIVE = 2;
	localparam int TK_FRM_BEGIN  = 3;
	localparam int TK_FRM_END    = 4;
	localparam int TK_FRM_ACTIVE = 5;
	localparam int TK_ROW_BEGIN  = 6;
	localparam int TK_EXP_START  = 7;
	localparam int TK_EXP_END    = 8;
	localparam int TK_EXP_ACTIVE = 9;

	localparam logic [3:0] ORG_SOFTWARE = 4'h0;

	localparam logic [15:0] RST_FRAME_TOTAL = 16'h0001;
	localparam logic [15:0] RST_LINES       = 16'h0001;
	localparam logic [23:0] RST_EXPO_CYC    = 24'h0003E8;
	localparam logic [31:0] RST_FRAME_HZ    = 32'h0000001E;
	localparam logic [31:0] RST_LINE_HZ     = 32'h00002710;

	typedef enum logic [1:0] {ONE_SHOT, COUNTED_BURST, CONTINUOUS} catc_policy_t;
	typedef enum logic [2:0] {UP_EDGE, DOWN_EDGE, EITHER_EDGE, WHILE_HIGH, WHILE_LOW} catc_qual_t;
	typedef enum logic [1:0] {NO_OVERLAP, POST_EXPOSURE_ACCEPT, ANYTIME_LATCH} catc_window_t;
	typedef enum logic [2:0] {S_IDLE, S_CHECK, S_ACQ_WAIT, S_FRM_WAIT, S_EXPOSE, S_POST_EXPOSURE_ACCEPT} catc_fsm_t;

	typedef struct packed {
		logic         exposing_now;
		logic         frm_moving_out;
		logic         frm_in_progress;
		logic         frm_awaiting_trigger;
		logic         acq_moving_out;
		logic         acq_in_progress;
		logic         acq_awaiting_trigger;
	} catc_status_t;

	typedef struct packed {
		logic         on;
		logic [3:0]   origin;
		catc_qual_t   qual;
		catc_window_t win;
		logic [15:0]  wait_units;
		logic [23:0]  wait_ns;
		logic [7:0]   ratio_down;
		logic [7:0]   ratio_up;
	} catc_trig_cfg_t;

	typedef struct packed {
		logic         dly_busy;
		logic [23:0]  dly_rem;
		logic [7:0]   div_cnt;
		logic [8:0]   mul_pend;
	} catc_trig_run_t;

	typedef struct packed {
		catc_fsm_t                      fsm;
		catc_policy_t                   policy;
		logic [15:0]                    frame_total;
		logic [15:0]                    lines_per_frame;
		logic [15:0]                    frames_done;
		logic [15:0]                    lines_done;
		logic [31:0]                    frame_hz;
		logic [31:0]                    frame_units;
		logic [31:0]                    line_hz;
		logic [31:0]                    line_units;
		logic [31:0]                    frame_acc;
		logic [31:0]                    line_acc;
		logic [23:0]                    expo_cycles;
		logic [23:0]                    expo_cnt;
		logic [2:0]                     status_pick;
		logic [3:0]                     trig_pick;
		catc_trig_cfg_t [NUM_TRIG-1:0]  cfg;
		catc_trig_run_t [NUM_TRIG-1:0]  run;
		logic [NUM_LINES-1:0]           s1;
		logic [NUM_LINES-1:0]           s2;
		logic [NUM_LINES-1:0]           s3;
		logic [NUM_LINES-1:0]           flt;
		logic [15:0]                    src_prev;
		logic                           validated;
		logic                           stop_req;
		logic                           frm_pending;
		logic                           acq_xfer;
		logic [15:0]                    xfer_cnt;
		catc_status_t                   stat;
		logic                           ack;
		logic [31:0]                    dat;
	} catc_state_t;
endpackage : catc_pkg

// file: verilog/catc_top.sv
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// (RQ1) first start validates implicitly unless already armed
// (RQ2) frame count below one clamps to one
// (RQ3) free-run frame rate in hertz when untriggered
// (RQ4) raw frame period overrides hertz when nonzero
// (RQ5) free-run line rate in hertz when untriggered
// (RQ6) raw line period overrides hertz when nonzero
// (RQ7) status selector picks one of seven signals
// (RQ8) acquisition wait, active, transfer status signals
// (RQ9) frame wait, active, transfer status signals
// (RQ10) exposure status exactly spans exposure period
// (RQ11) status read returns selected signal, read-only
// (RQ12) triggers start acquisition, frame, line, exposure
// (RQ13) selector addresses ten trigger kinds
// (RQ14) trigger off ignored, on gates event
// (RQ15) source software, line, timer, counter, user bit
// (RQ16) software fire command makes one trigger pulse
// (RQ17) activation rising, falling, either, high, low
// (RQ18) overlap: none, after exposure, latch anytime
// (RQ19) programmable delay, absolute and raw forms
// (RQ20) divider and multiplier set trigger ratio
// (RQ21) one, counted or continuous frames per acquisition
// (RQ22) stop ends after frame, cancels pending, idle ignored
// (RQ23) abort ends capture at once, idle ignored
// (RQ24) level activation valid while level holds
// (RQ25) external lines synchronised before qualification
module catc_top #(
	parameter logic [15:0] XFER_CYCLES = 16'h0010
) (
	input  wire logic                               clk_i,           // 200 MHz
	input  wire logic                               rst_i,           // sync, active high
	input  wire logic                               wb_cyc_i,        // bus cycle
	input  wire logic                               wb_stb_i,        // strobe
	input  wire logic                               wb_we_i,         // write
	input  wire logic [7:0]                         wb_adr_i,        // byte address
	input  wire logic [3:0]                         wb_sel_i,        // byte enables
	input  wire logic [31:0]                        wb_dat_i,        // write data
	output logic      [31:0]                        wb_dat_o,        // read data
	output logic                                    wb_ack_o,        // acknowledge
	input  wire logic [catc_pkg::NUM_LINES-1:0]     trig_line_i,     // async trigger pins
	input  wire logic [1:0]                         timer_start_i,   // timer start signals
	input  wire logic [1:0]                         timer_end_i,     // timer end signals
	input  wire logic [1:0]                         counter_start_i, // counter start signals
	input  wire logic [1:0]                         counter_end_i,   // counter end signals
	input  wire logic [1:0]                         user_bit_i,      // user output bits
	output catc_pkg::catc_status_t                  status_o         // acquisition status
);
	catc_pkg::catc_state_t                st;
	catc_pkg::catc_state_t                nx;
	logic [catc_pkg::NUM_TRIG-1:0]        hit;
	logic [catc_pkg::NUM_TRIG-1:0]        held;
	logic [catc_pkg::NUM_TRIG-1:0]        fire;
	logic [15:0]                          src_now;
	logic                                 req;
	logic                                 wr;
	logic [7:0]                           adr;
	logic [31:0]                          rd_word;
	logic [31:0]                          wd;
	logic                                 cmd_arm;
	logic                                 cmd_begin;
	logic                                 cmd_finish;
	logic                                 cmd_kill;
	logic                                 cmd_fire;
	logic                                 frame_tick;
	logic                                 line_tick;
	logic [catc_pkg::NUM_STAT-1:0]        stat_vec;

	function automatic logic [32:0] rate_step(input logic [31:0] acc, input logic [31:0] hz,
		input logic [31:0] units);
		logic [32:0] sum;
		sum = {1'b0, acc} + {1'b0, hz};
		if (units != 32'h00000000)
			rate_step = (acc + 32'h00000001 >= units) ? {1'b1, 32'h00000000} : {1'b0, acc + 32'h00000001};
		else if (sum >= {1'b0, catc_pkg::CLK_HZ})
			rate_step = {1'b1, 32'(sum - {1'b0, catc_pkg::CLK_HZ})};
		else
			rate_step = sum;
	endfunction : rate_step

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		for (int b = 0; b < 4; b++)
			wmerge[8*b +: 8] = sel[b] ? nw[8*b +: 8] : old[8*b +: 8];
	endfunction : wmerge

	function automatic logic [31:0] clamp_hz(input logic [31:0] v);
		clamp_hz = (v > catc_pkg::CLK_HZ) ? catc_pkg::CLK_HZ : v;
	endfunction : clamp_hz

	assign req        = wb_cyc_i & wb_stb_i & ~st.ack;
	assign wr         = req & wb_we_i;
	assign adr        = {wb_adr_i[7:2], 2'b00};
	assign wd         = wmerge(rd_word, wb_dat_i, wb_sel_i);
	assign cmd_arm    = wr & (adr == catc_pkg::ADR_CMD) & wb_sel_i[0] & wb_dat_i[catc_pkg::CMD_ARM];
	assign cmd_begin  = wr & (adr == catc_pkg::ADR_CMD) & wb_sel_i[0] & wb_dat_i[catc_pkg::CMD_BEGIN];
	assign cmd_finish = wr & (adr == catc_pkg::ADR_CMD) & wb_sel_i[0] & wb_dat_i[catc_pkg::CMD_FINISH];
	assign cmd_kill   = wr & (adr == catc_pkg::ADR_CMD) & wb_sel_i[0] & wb_dat_i[catc_pkg::CMD_KILL];
	assign cmd_fire   = wr & (adr == catc_pkg::ADR_CMD) & wb_sel_i[0] & wb_dat_i[catc_pkg::CMD_FIRE];
	assign stat_vec   = st.stat;

	// origin code indexes this vector; code 0 is software, unused codes read low
	assign src_now = {2'b00, user_bit_i, counter_end_i, counter_start_i, timer_end_i, timer_start_i,
		st.flt, 1'b0}; // RQ15

	// qualify each trigger's source into an event and a level
	for (genvar g = 0; g < catc_pkg::NUM_TRIG; g++)
	begin : g_qual
		logic cur;
		logic prv;
		catc_pkg::catc_trig_cfg_t cf;
		assign cf  = st.cfg[g];
		assign cur = src_now[cf.origin];
		assign prv = st.src_prev[cf.origin];
		always_comb
		begin
			hit[g]  = 1'b0;
			held[g] = 1'b0;
			if (cf.on && cf.origin == catc_pkg::ORG_SOFTWARE) // RQ14
				hit[g] = cmd_fire & (st.trig_pick == 4'(g)); // RQ16
			else if (cf.on)
			begin
				unique case (cf.qual) // RQ17
					catc_pkg::UP_EDGE:     hit[g] = cur & ~prv;
					catc_pkg::DOWN_EDGE:   hit[g] = ~cur & prv;
					catc_pkg::EITHER_EDGE: hit[g] = cur ^ prv;
					catc_pkg::WHILE_HIGH:  hit[g] = cur; // RQ24
					catc_pkg::WHILE_LOW:   hit[g] = ~cur; // RQ24
					default:               hit[g] = 1'b0;
				endcase
				held[g] = (cf.qual == catc_pkg::WHILE_HIGH) ? cur : (cf.qual == catc_pkg::WHILE_LOW) ? ~cur : 1'b0;
			end
		end
	end

	always_comb
	begin
		unique case (adr)
			catc_pkg::ADR_CTRL:        rd_word = {30'h0, st.policy};
			catc_pkg::ADR_FRAME_TOTAL: rd_word = {16'h0, st.frame_total};
			catc_pkg::ADR_FRAME_HZ:    rd_word = st.frame_hz;
			catc_pkg::ADR_FRAME_UNITS: rd_word = st.frame_units;
			catc_pkg::ADR_LINE_HZ:     rd_word = st.line_hz;
			catc_pkg::ADR_LINE_UNITS:  rd_word = st.line_units;
			catc_pkg::ADR_STAT_PICK:   rd_word = {29'h0, st.status_pick}; // RQ7
			catc_pkg::ADR_STAT_VALUE:  rd_word = {31'h0, stat_vec[st.status_pick]}; // RQ11
			catc_pkg::ADR_TRIG_PICK:   rd_word = {28'h0, st.trig_pick}; // RQ13
			catc_pkg::ADR_TRIG_CFG:    rd_word = {18'h0, st.cfg[st.trig_pick].win, 1'b0, st.cfg[st.trig_pick].qual,
				st.cfg[st.trig_pick].origin, 3'b000, st.cfg[st.trig_pick].on};
			catc_pkg::ADR_TRIG_WAIT:   rd_word = {16'h0, st.cfg[st.trig_pick].wait_units};
			catc_pkg::ADR_TRIG_WAITNS: rd_word = {8'h0, st.cfg[st.trig_pick].wait_ns};
			catc_pkg::ADR_TRIG_RATIO:  rd_word = {16'h0, st.cfg[st.trig_pick].ratio_up, st.cfg[st.trig_pick].ratio_down};
			catc_pkg::ADR_EXPO_CYC:    rd_word = {8'h0, st.expo_cycles};
			catc_pkg::ADR_LINES:       rd_word = {16'h0, st.lines_per_frame};
			default:                   rd_word = 32'h00000000;
		endcase
	end

	always_comb
	begin
		logic         frm_trig_on;
		logic         frm_trig;
		logic         frm_go;
		logic         acq_go;
		logic         acq_stop;
		logic         expo_done;
		logic         line_ev;
		logic         ro_done;
		logic [15:0]  frames_next;
		logic [9:0]   pend_sum;
		catc_pkg::catc_window_t win;
		frm_trig_on = 1'b0;
		frm_trig = 1'b0;
		frm_go = 1'b0;
		acq_go = 1'b0;
		acq_stop = 1'b0;
		expo_done = 1'b0;
		line_ev = 1'b0;
		ro_done = 1'b0;
		frames_next = 16'h0000;
		pend_sum = 10'h000;
		win = catc_pkg::NO_OVERLAP;
		nx = st;
		nx.ack = wb_cyc_i & wb_stb_i & ~st.ack;
		nx.dat = (req & ~wb_we_i) ? rd_word : 32'h00000000;

		// three-stage sync; a change counts once stages two and three agree
		nx.s1 = trig_line_i; // RQ25
		nx.s2 = st.s1;
		nx.s3 = st.s2;
		nx.flt = ((st.s2 ~^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.flt); // RQ25
		nx.src_prev = src_now;

		{frame_tick, nx.frame_acc} = rate_step(st.frame_acc, st.frame_hz, st.frame_units); // RQ3 RQ4
		{line_tick, nx.line_acc} = rate_step(st.line_acc, st.line_hz, st.line_units); // RQ5 RQ6

		// delay, then divider, then multiplier; one trigger in flight per kind
		for (int i = 0; i < catc_pkg::NUM_TRIG; i++)
		begin
			fire[i] = st.run[i].mul_pend != 9'h000;
			pend_sum = {1'b0, st.run[i].mul_pend} - {9'h000, fire[i]};
			if (st.run[i].dly_busy)
			begin
				if (st.run[i].dly_rem > catc_pkg::CLK_PERIOD_NS) // RQ19
					nx.run[i].dly_rem = st.run[i].dly_rem - catc_pkg::CLK_PERIOD_NS;
				else
				begin
					nx.run[i].dly_busy = 1'b0;
					if ({1'b0, st.run[i].div_cnt} + 9'h001 >= {1'b0, st.cfg[i].ratio_down}) // RQ20
					begin
						nx.run[i].div_cnt = 8'h00;
						pend_sum = pend_sum + ((st.cfg[i].ratio_up == 8'h00) ? 10'h001 : {2'b00, st.cfg[i].ratio_up});
					end
					else
						nx.run[i].div_cnt = st.run[i].div_cnt + 8'h01;
				end
			end
			else if (hit[i])
			begin
				nx.run[i].dly_busy = 1'b1;
				nx.run[i].dly_rem = (st.cfg[i].wait_units != 16'h0000) ? // RQ19
					24'({8'h00, st.cfg[i].wait_units} * catc_pkg::CLK_PERIOD_NS) : st.cfg[i].wait_ns;
			end
			nx.run[i].mul_pend = pend_sum[9] ? 9'h1FF : pend_sum[8:0];
			if (!st.cfg[i].on) // RQ14
				nx.run[i] = '0;
		end

		win = st.cfg[catc_pkg::TK_FRM_BEGIN].win;
		frm_trig_on = st.cfg[catc_pkg::TK_FRM_BEGIN].on | st.cfg[catc_pkg::TK_FRM_ACTIVE].on |
			st.cfg[catc_pkg::TK_EXP_START].on; // RQ12
		frm_trig = fire[catc_pkg::TK_FRM_BEGIN] | fire[catc_pkg::TK_EXP_START] | held[catc_pkg::TK_FRM_ACTIVE];
		frm_go = frm_trig_on ? frm_trig : frame_tick; // RQ3
		acq_go = (st.cfg[catc_pkg::TK_ACQ_START].on | st.cfg[catc_pkg::TK_ACQ_ACTIVE].on) ?
			(fire[catc_pkg::TK_ACQ_START] | held[catc_pkg::TK_ACQ_ACTIVE]) : 1'b1; // RQ12
		acq_stop = fire[catc_pkg::TK_ACQ_END] | (st.cfg[catc_pkg::TK_ACQ_ACTIVE].on & ~held[catc_pkg::TK_ACQ_ACTIVE] &
			(st.fsm inside {catc_pkg::S_FRM_WAIT, catc_pkg::S_EXPOSE, catc_pkg::S_POST_EXPOSURE_ACCEPT}));
		expo_done = st.cfg[catc_pkg::TK_EXP_END].on ? fire[catc_pkg::TK_EXP_END] :
			st.cfg[catc_pkg::TK_EXP_ACTIVE].on ? ~held[catc_pkg::TK_EXP_ACTIVE] : (st.expo_cnt <= 24'h000001); // RQ12
		line_ev = st.cfg[catc_pkg::TK_ROW_BEGIN].on ? fire[catc_pkg::TK_ROW_BEGIN] : line_tick; // RQ5
		ro_done = fire[catc_pkg::TK_FRM_END] | (line_ev & (st.lines_done + 16'h0001 >= st.lines_per_frame));
		frames_next = st.frames_done + 16'h0001;

		if (st.xfer_cnt != 16'h0000)
			nx.xfer_cnt = st.xfer_cnt - 16'h0001;

		unique case (st.fsm)
			catc_pkg::S_IDLE:
				if (cmd_begin)
				begin
					nx.frames_done = 16'h0000;
					nx.stop_req = 1'b0;
					nx.frm_pending = 1'b0;
					nx.fsm = st.validated ? catc_pkg::S_ACQ_WAIT : catc_pkg::S_CHECK; // RQ1
				end
			catc_pkg::S_CHECK:
			begin
				nx.validated = 1'b1; // RQ1
				nx.fsm = catc_pkg::S_ACQ_WAIT;
			end
			catc_pkg::S_ACQ_WAIT:
				if (acq_go)
					nx.fsm = catc_pkg::S_FRM_WAIT;
			catc_pkg::S_FRM_WAIT:
				if (frm_go | st.frm_pending) // RQ14
				begin
					nx.fsm = catc_pkg::S_EXPOSE;
					nx.expo_cnt = st.expo_cycles;
					nx.frm_pending = 1'b0;
				end
			catc_pkg::S_EXPOSE:
			begin
				if (frm_trig_on & frm_trig & (win == catc_pkg::ANYTIME_LATCH)) // RQ18
					nx.frm_pending = 1'b1;
				nx.expo_cnt = st.expo_cnt - 24'h000001;
				if (expo_done) // RQ10
				begin
					nx.fsm = catc_pkg::S_POST_EXPOSURE_ACCEPT;
					nx.lines_done = 16'h0000;
					nx.xfer_cnt = XFER_CYCLES;
					nx.acq_xfer = 1'b1;
				end
			end
			catc_pkg::S_POST_EXPOSURE_ACCEPT:
			begin
				if (frm_trig_on & frm_trig & (win != catc_pkg::NO_OVERLAP)) // RQ18
					nx.frm_pending = 1'b1;
				if (line_ev)
					nx.lines_done = st.lines_done + 16'h0001;
				if (ro_done)
				begin
					nx.frames_done = frames_next;
					if ((st.policy == catc_pkg::ONE_SHOT) || st.stop_req ||
						((st.policy == catc_pkg::COUNTED_BURST) && (frames_next >= st.frame_total))) // RQ21
					begin
						nx.fsm = catc_pkg::S_IDLE;
						nx.frm_pending = 1'b0;
					end
					else if (st.frm_pending)
					begin
						nx.fsm = catc_pkg::S_EXPOSE;
						nx.expo_cnt = st.expo_cycles;
						nx.frm_pending = 1'b0;
					end
					else
						nx.fsm = catc_pkg::S_FRM_WAIT;
				end
			end
		endcase

		if ((cmd_finish | acq_stop) && st.fsm != catc_pkg::S_IDLE) // RQ22
		begin
			nx.frm_pending = 1'b0;
			if (st.fsm inside {catc_pkg::S_EXPOSE, catc_pkg::S_POST_EXPOSURE_ACCEPT})
				nx.stop_req = 1'b1;
			else
				nx.fsm = catc_pkg::S_IDLE;
		end
		if (cmd_kill && st.fsm != catc_pkg::S_IDLE) // RQ23
		begin
			nx.fsm = catc_pkg::S_IDLE;
			nx.frm_pending = 1'b0;
			nx.stop_req = 1'b0;
		end
		if (nx.fsm == catc_pkg::S_IDLE && nx.xfer_cnt == 16'h0000)
			nx.acq_xfer = 1'b0;

		// any feature write undoes the freeze so the next start re-validates
		if (wr && adr != catc_pkg::ADR_CMD && adr != catc_pkg::ADR_STAT_VALUE)
			nx.validated = 1'b0; // RQ1
		if (cmd_arm)
			nx.validated = 1'b1; // RQ1
		if (wr)
		begin
			unique case (adr)
				catc_pkg::ADR_CTRL:
					if (wd[1:0] != 2'b11)
						nx.policy = catc_pkg::catc_policy_t'(wd[1:0]);
				catc_pkg::ADR_FRAME_TOTAL: nx.frame_total = (wd[15:0] == 16'h0000) ? 16'h0001 : wd[15:0]; // RQ2
				catc_pkg::ADR_FRAME_HZ:    nx.frame_hz = clamp_hz(wd); // RQ3
				catc_pkg::ADR_FRAME_UNITS: nx.frame_units = wd; // RQ4
				catc_pkg::ADR_LINE_HZ:     nx.line_hz = clamp_hz(wd); // RQ5
				catc_pkg::ADR_LINE_UNITS:  nx.line_units = wd; // RQ6
				catc_pkg::ADR_STAT_PICK:
					if (wd[2:0] < 3'(catc_pkg::NUM_STAT))
						nx.status_pick = wd[2:0]; // RQ7
				catc_pkg::ADR_TRIG_PICK:
					if (wd[3:0] < 4'(catc_pkg::NUM_TRIG))
						nx.trig_pick = wd[3:0]; // RQ13
				catc_pkg::ADR_TRIG_CFG:
				begin
					nx.cfg[st.trig_pick].on = wd[catc_pkg::CFG_ON];
					nx.cfg[st.trig_pick].origin = wd[catc_pkg::CFG_ORIGIN_LSB +: 4]; // RQ15
					nx.cfg[st.trig_pick].qual = catc_pkg::catc_qual_t'(wd[catc_pkg::CFG_QUAL_LSB +: 3]);
					nx.cfg[st.trig_pick].win = catc_pkg::catc_window_t'(wd[catc_pkg::CFG_WIN_LSB +: 2]);
				end
				catc_pkg::ADR_TRIG_WAIT:   nx.cfg[st.trig_pick].wait_units = wd[15:0];
				catc_pkg::ADR_TRIG_WAITNS: nx.cfg[st.trig_pick].wait_ns = wd[23:0];
				catc_pkg::ADR_TRIG_RATIO:
				begin
					nx.cfg[st.trig_pick].ratio_down = wd[7:0];
					nx.cfg[st.trig_pick].ratio_up = wd[catc_pkg::RATIO_UP_LSB +: 8];
				end
				catc_pkg::ADR_EXPO_CYC:    nx.expo_cycles = (wd[23:0] == 24'h000000) ? 24'h000001 : wd[23:0];
				catc_pkg::ADR_LINES:       nx.lines_per_frame = (wd[15:0] == 16'h0000) ? 16'h0001 : wd[15:0];
				default:                   nx.policy = st.policy;
			endcase
		end

		// status is taken from the next state so it lines up with the fsm itself
		nx.stat.acq_awaiting_trigger = nx.fsm == catc_pkg::S_ACQ_WAIT; // RQ8
		nx.stat.acq_in_progress = nx.fsm inside {catc_pkg::S_FRM_WAIT, catc_pkg::S_EXPOSE, catc_pkg::S_POST_EXPOSURE_ACCEPT};
		nx.stat.acq_moving_out = nx.acq_xfer; // RQ8
		nx.stat.frm_awaiting_trigger = nx.fsm == catc_pkg::S_FRM_WAIT; // RQ9
		nx.stat.frm_in_progress = nx.fsm inside {catc_pkg::S_EXPOSE, catc_pkg::S_POST_EXPOSURE_ACCEPT};
		nx.stat.frm_moving_out = nx.xfer_cnt != 16'h0000; // RQ9
		nx.stat.exposing_now = nx.fsm == catc_pkg::S_EXPOSE; // RQ10
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st <= '0;
			st.frame_total <= catc_pkg::RST_FRAME_TOTAL;
			st.lines_per_frame <= catc_pkg::RST_LINES;
			st.expo_cycles <= catc_pkg::RST_EXPO_CYC;
			st.frame_hz <= catc_pkg::RST_FRAME_HZ;
			st.line_hz <= catc_pkg::RST_LINE_HZ;
		end
		else
			st <= nx;
	end

	assign wb_ack_o = st.ack;
	assign wb_dat_o = st.dat;
	assign status_o = st.stat;
endmodule : catc_top
